//--- rtl/lchb_loop_top.sv
// Loop control with zero-overhead and conditional hardware branching
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`include "lchb_regs.svh"

module lchb_loop_top #(
    parameter int NSETS = `LCHB_NSETS,
    parameter int CTR_W = `LCHB_CTR_W,
    parameter logic [`LCHB_PC_W-1:0] RESET_PC = `LCHB_RESET_PC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite slave
    input wire logic [`LCHB_AXI_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [`LCHB_DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [`LCHB_AXI_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [`LCHB_DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Pipeline side
    input wire lchb_pkg::lchb_fetch_s fetch_i,
    input wire logic exe_wr_i,
    input wire logic [`LCHB_IDX_W-1:0] exe_wr_idx_i,
    input wire logic [`LCHB_DATA_W-1:0] exe_wr_data_i,
    output logic [`LCHB_PC_W-1:0] fetch_pc_o,
    output logic loop_taken_o
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (NSETS < 1 || NSETS > `LCHB_MAX_SETS) begin : g_bad_sets
        $error("NSETS must be 1 to 3");
    end
    if (CTR_W < 1 || CTR_W > `LCHB_DATA_W) begin : g_bad_ctr
        $error("CTR_W must be 1 to 32");
    end

    // ****************************************
    // Declarations
    // ****************************************
    logic [`LCHB_PC_W-1:0] pc_ff;           // Fetch address
    logic [`LCHB_PC_W-1:0] nxt_pc;          // Next fetch address
    logic taken_ff;                         // Last fetch took a loop branch
    logic nxt_taken;                        // Loop branch this cycle
    logic [`LCHB_PC_W-1:0] end_ff [NSETS];  // Loop end addresses
    logic [`LCHB_PC_W-1:0] start_ff [NSETS]; // Loop start addresses
    lchb_pkg::lchb_ctl_s ctl_ff [NSETS];    // Per loop end control
    logic [CTR_W-1:0] cnt [NSETS];          // Counter values
    logic [NSETS-1:0] cnt_nz;               // Counter nonzero flags
    logic [NSETS-1:0] step;                 // Counter step requests
    logic [NSETS-1:0] cnt_wr;               // Counter write strobes
    logic [NSETS-1:0] rld_wr;               // Reload write strobes
    logic [`LCHB_PC_W-1:0] tgt;             // Winning loop start
    // Bus write path
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic [`LCHB_IDX_W-1:0] aw_idx_ff;      // Held write word index
    logic aw_ok_ff;                         // Held write address mapped
    logic [`LCHB_DATA_W-1:0] wdata_ff;      // Held write data
    logic [3:0] wstrb_ff;                   // Held byte enables
    logic axi_wr_go;                        // Bus write performed now
    logic [`LCHB_DATA_W-1:0] merged;        // Byte merged bus data
    // Bus read path
    logic arready_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [`LCHB_DATA_W-1:0] rdata_ff;
    // Shared write port
    logic wr_en;
    logic [`LCHB_IDX_W-1:0] wr_idx;
    logic [`LCHB_DATA_W-1:0] wr_val;

    // ****************************************
    // Register map helpers
    // ****************************************
    // Address maps to a register
    function automatic logic mapped(input logic [`LCHB_AXI_AW-1:0] a);
        logic [`LCHB_IDX_W-1:0] ix;
        ix = a[5:2];
        mapped = (a[7:6] == 2'h0) && ((int'(ix) < 4 * NSETS)
            || ix == `LCHB_IDX_CTRL || ix == `LCHB_IDX_STATUS
            || ix == `LCHB_IDX_PC);
    endfunction

    // Read value of one register word
    function automatic logic [`LCHB_DATA_W-1:0] reg_word(
        input logic [`LCHB_IDX_W-1:0] ix);
        logic [`LCHB_DATA_W-1:0] v;
        v = '0;
        for (int i = 0; i < NSETS; i++) begin
            if (ix[3:2] == 2'(i)) begin
                unique case (ix[1:0])
                    `LCHB_FLD_END: v = end_ff[i];
                    `LCHB_FLD_START: v = start_ff[i];
                    `LCHB_FLD_COUNT: v = `LCHB_DATA_W'(cnt[i]);
                    `LCHB_FLD_RELOAD: v = '0; // Reload reads as zero
                endcase
            end
            // Control fields packed four bits per loop end
            if (ix == `LCHB_IDX_CTRL) begin
                v[i*`LCHB_CTL_FLD_W +: `LCHB_CTL_FLD_W] = ctl_ff[i];
            end
            // Status: taken flag in bit 0, nonzero flags from bit 4
            if (ix == `LCHB_IDX_STATUS) begin
                v[4+i] = cnt_nz[i];
            end
        end
        if (ix == `LCHB_IDX_STATUS) begin
            v[0] = taken_ff;
        end
        if (ix == `LCHB_IDX_PC) begin
            v = pc_ff;
        end
        return v;
    endfunction

    // ****************************************
    // Loop end compare and fetch redirect
    // ****************************************
    // Lowest first so a higher loop end overrides a lower one
    always_comb begin
        step = '0;
        nxt_taken = 1'b0;
        tgt = start_ff[0];
        for (int i = 0; i < NSETS; i++) begin
            // Compare against the live counter; a write from execute lands
            // while the two younger fetches proceed as delay slots
            if (fetch_i.adv && ctl_ff[i].en && pc_ff == end_ff[i]) begin
                if (ctl_ff[i].sel == 2'h0) begin
                    nxt_taken = 1'b1;
                    tgt = start_ff[i];
                end else if (int'(ctl_ff[i].sel) <= NSETS) begin
                    if (!fetch_i.sw_branch) begin
                        step[int'(ctl_ff[i].sel) - 1] = 1'b1;
                    end
                    if (cnt_nz[int'(ctl_ff[i].sel) - 1]) begin
                        nxt_taken = 1'b1;
                        tgt = start_ff[i];
                    end
                end
            end
        end
        // Software branch dominates the loop logic
        if (fetch_i.sw_branch) begin
            nxt_taken = 1'b0;
        end
    end

    // Next fetch address
    always_comb begin
        if (!fetch_i.adv) begin
            nxt_pc = pc_ff;
        end else if (fetch_i.sw_branch) begin
            nxt_pc = fetch_i.sw_target;
        end else if (nxt_taken) begin
            nxt_pc = tgt;
        end else begin
            nxt_pc = pc_ff + `LCHB_PC_STEP;
        end
    end

    // Fetch address register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_ff <= RESET_PC;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // Taken flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            taken_ff <= 1'b0;
        end else begin
            taken_ff <= nxt_taken;
        end
    end

    // ****************************************
    // Shared register write port
    // ****************************************
    // Execute stage writes win; the bus write waits while exe_wr_i is high
    always_comb begin
        merged = reg_word(aw_idx_ff);
        for (int b = 0; b < 4; b++) begin
            if (wstrb_ff[b]) begin
                merged[b*8 +: 8] = wdata_ff[b*8 +: 8];
            end
        end
        axi_wr_go = !awready_ff && !wready_ff && !bvalid_ff && !exe_wr_i;
        wr_en = exe_wr_i || (axi_wr_go && aw_ok_ff);
        wr_idx = exe_wr_i ? exe_wr_idx_i : aw_idx_ff;
        wr_val = exe_wr_i ? exe_wr_data_i : merged;
    end

    // ****************************************
    // Per set storage
    // ****************************************
    for (genvar i = 0; i < NSETS; i++) begin : g_set
        assign cnt_wr[i] = wr_en && wr_idx == {2'(i), `LCHB_FLD_COUNT};
        assign rld_wr[i] = wr_en && wr_idx == {2'(i), `LCHB_FLD_RELOAD};

        // Loop end and start addresses
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                end_ff[i] <= '0;
                start_ff[i] <= '0;
            end else if (wr_en && wr_idx == {2'(i), `LCHB_FLD_END}) begin
                end_ff[i] <= wr_val;
            end else if (wr_en && wr_idx == {2'(i), `LCHB_FLD_START}) begin
                start_ff[i] <= wr_val;
            end
        end

        // Control field; a reload write also enables this loop end
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                ctl_ff[i] <= '0;
            end else if (wr_en && wr_idx == `LCHB_IDX_CTRL) begin
                ctl_ff[i] <= wr_val[i*`LCHB_CTL_FLD_W +: `LCHB_CTL_FLD_W];
            end else if (rld_wr[i]) begin
                ctl_ff[i].en <= 1'b1;
            end
        end

        // Counter with reload
        lchb_loop_ctr #(
            .CTR_W(CTR_W)
        ) u_ctr (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cnt_wr_i(cnt_wr[i]),
            .rld_wr_i(rld_wr[i]),
            .wr_data_i(wr_val[CTR_W-1:0]),
            .step_i(step[i]),
            .cnt_o(cnt[i]),
            .nonzero_o(cnt_nz[i])
        );
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    // Address capture; ready returns after the response is taken
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            awready_ff <= 1'b1;
            aw_idx_ff <= '0;
            aw_ok_ff <= 1'b0;
        end else if (s_axi_awvalid_i && awready_ff) begin
            awready_ff <= 1'b0;
            aw_idx_ff <= s_axi_awaddr_i[5:2];
            aw_ok_ff <= mapped(s_axi_awaddr_i);
        end else if (bvalid_ff && s_axi_bready_i) begin
            awready_ff <= 1'b1;
        end
    end

    // Data capture, independent of the address
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wready_ff <= 1'b1;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (s_axi_wvalid_i && wready_ff) begin
            wready_ff <= 1'b0;
            wdata_ff <= s_axi_wdata_i;
            wstrb_ff <= s_axi_wstrb_i;
        end else if (bvalid_ff && s_axi_bready_i) begin
            wready_ff <= 1'b1;
        end
    end

    // Response once both halves are held and the write is done
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `LCHB_RESP_OKAY;
        end else if (axi_wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= aw_ok_ff ? `LCHB_RESP_OKAY : `LCHB_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    // One read at a time; data sampled at the address edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rresp_ff <= `LCHB_RESP_OKAY;
            rdata_ff <= '0;
        end else if (s_axi_arvalid_i && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            if (mapped(s_axi_araddr_i)) begin
                rresp_ff <= `LCHB_RESP_OKAY;
                rdata_ff <= reg_word(s_axi_araddr_i[5:2]);
            end else begin
                rresp_ff <= `LCHB_RESP_SLVERR;
                rdata_ff <= '0;
            end
        end else if (rvalid_ff && s_axi_rready_i) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready_o = awready_ff;
    assign s_axi_wready_o = wready_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = arready_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign fetch_pc_o = pc_ff;
    assign loop_taken_o = taken_ff;

endmodule

//--- shared/lchb_regs.svh
// Constants for the loop control and conditional hardware branch block
// Behaviour
// - Counter written two instructions early decides the branch
// - Loop end fetch loads loop start if counter nonzero
// - Counter write beats same-cycle automatic decrement
// - Two already fetched instructions execute as delay slots
// - Zero reload clears counter and enables loop end
// - Reload value N gives N plus one passes
// - Unconditional mode branches always, never decrements
// - Branch on every fetch, no delay cycles
// - Software branch wins; counters frozen that cycle
// - Higher numbered loop end wins when both matching ends branch
`ifndef LCHB_REGS_SVH
`define LCHB_REGS_SVH

// ****************************************
// Widths and sizes
// ****************************************
`define LCHB_DATA_W 32
`define LCHB_AXI_AW 8
`define LCHB_PC_W 32
`define LCHB_CTR_W 16
`define LCHB_NSETS 3
`define LCHB_MAX_SETS 3
`define LCHB_IDX_W 4
`define LCHB_CTL_FLD_W 4

// ****************************************
// Reset values and fetch step
// ****************************************
`define LCHB_RESET_PC 32'h0000_0000
`define LCHB_PC_STEP 32'h0000_0001

// ****************************************
// Register word indices (byte address = 4 * index)
// ****************************************
`define LCHB_FLD_END 2'h0
`define LCHB_FLD_START 2'h1
`define LCHB_FLD_COUNT 2'h2
`define LCHB_FLD_RELOAD 2'h3
`define LCHB_IDX_CTRL 4'hC
`define LCHB_IDX_STATUS 4'hD
`define LCHB_IDX_PC 4'hE

// ****************************************
// Bus answers
// ****************************************
`define LCHB_RESP_OKAY 2'h0
`define LCHB_RESP_SLVERR 2'h2

`endif

//--- shared/lchb_pkg.sv
// Types shared by the loop control block
package lchb_pkg;

    // Per loop end control field: enable and counter selection
    typedef struct packed {
        logic en;       // Loop end comparison enabled
        logic spare;    // Reads back as written, no effect
        logic [1:0] sel; // 0 = unconditional, k = counter k-1
    } lchb_ctl_s;

    // Fetch side request from the pipeline
    typedef struct packed {
        logic adv;                  // Fetch advances this cycle
        logic sw_branch;            // Software branch loads the PC
        logic [31:0] sw_target;     // Software branch target
    } lchb_fetch_s;

endpackage

//--- rtl/lchb_loop_ctr.sv
// One loop counter with its reload value
`include "lchb_regs.svh"

module lchb_loop_ctr #(
    parameter int CTR_W = `LCHB_CTR_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cnt_wr_i,              // Software write of the counter
    input wire logic rld_wr_i,              // Software write of the reload value
    input wire logic [CTR_W-1:0] wr_data_i, // Written value
    input wire logic step_i,                // Loop end reached with this counter
    output logic [CTR_W-1:0] cnt_o,         // Current count
    output logic nonzero_o                  // Count is not zero
);

    logic [CTR_W-1:0] cnt_ff; // Live counter
    logic [CTR_W-1:0] rld_ff; // Reload value

    // ****************************************
    // Counter update
    // ****************************************
    // Software writes take precedence over the automatic step
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else if (cnt_wr_i || rld_wr_i) begin
            cnt_ff <= wr_data_i;
        end else if (step_i) begin
            // Nonzero counts down; zero reloads for the next pass set
            if (nonzero_o) begin
                cnt_ff <= cnt_ff - CTR_W'(1);
            end else begin
                cnt_ff <= rld_ff;
            end
        end
    end

    // Reload value holds until rewritten
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rld_ff <= '0;
        end else if (rld_wr_i) begin
            rld_ff <= wr_data_i;
        end
    end

    assign cnt_o = cnt_ff;
    assign nonzero_o = (cnt_ff != '0);

endmodule

//--- verification/lchb_loop_top_monitor.sv
// Port checker for the loop control block
`include "lchb_regs.svh"

module lchb_loop_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [`LCHB_AXI_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [`LCHB_DATA_W-1:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire lchb_pkg::lchb_fetch_s fetch_i,
    input wire logic [`LCHB_PC_W-1:0] fetch_pc_o,
    input wire logic loop_taken_o
);
    // ********
    // Clocking
    // ********
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ********
    // Fetch side
    // ********
    // Software branch target wins, no loop flag
    property p_sw_wins;
        fetch_i.adv && fetch_i.sw_branch |=>
            fetch_pc_o == $past(fetch_i.sw_target) && !loop_taken_o;
    endproperty
    a_sw_wins: assert property (p_sw_wins) else $error("sw branch lost");
    // Without a loop the fetch steps by one
    property p_seq;
        fetch_i.adv && !fetch_i.sw_branch |=>
            loop_taken_o || fetch_pc_o == $past(fetch_pc_o) + 32'h1;
    endproperty
    a_seq: assert property (p_seq) else $error("bad sequential step");
    // A loop branch needs a plain fetch one cycle before
    property p_taken_src;
        loop_taken_o |-> $past(fetch_i.adv) && !$past(fetch_i.sw_branch);
    endproperty
    a_taken_src: assert property (p_taken_src) else $error("stray loop branch");
    // No fetch holds the address
    property p_hold;
        !fetch_i.adv |=> $stable(fetch_pc_o) && !loop_taken_o;
    endproperty
    a_hold: assert property (p_hold) else $error("pc moved while stalled");

    // ********
    // Register bus
    // ********
    // Read data one cycle after the address is taken
    property p_r_lat;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    // Write response clears after its handshake
    property p_b_done;
        s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write response stuck");
    // Only one write under way
    property p_one_wr;
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
    endproperty
    a_one_wr: assert property (p_one_wr) else $error("write taken early");
    // Unmapped read gives an error and zero data
    property p_unmapped;
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i >= 8'h3C |=>
            s_axi_rresp_o == `LCHB_RESP_SLVERR && s_axi_rdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    // Reading the PC word returns the fetch address
    property p_rd_pc;
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 8'h38 |=>
            s_axi_rdata_o == $past(fetch_pc_o);
    endproperty
    a_rd_pc: assert property (p_rd_pc) else $error("pc readback wrong");
endmodule

bind lchb_loop_top lchb_loop_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .fetch_i(fetch_i),
    .fetch_pc_o(fetch_pc_o), .loop_taken_o(loop_taken_o)
);

//--- verification/lchb_loop_top_tb.sv
// Testbench for the loop control block
`include "lchb_regs.svh"

module lchb_loop_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Signals
    // ********
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    // Response ready lines stay high: the master is always willing to take answers
    logic awv = 1'b0, wv = 1'b0, br = 1'b1, arv = 1'b0, rr = 1'b1, ew = 1'b0;
    logic [31:0] wd = 32'h0, ed = 32'h0, rd, pc, xp;
    logic [3:0] ei = 4'h0, ws = 4'hF;
    logic awr, wr, bv, arr, rv, tk, xt;
    logic [1:0] bre, rre;
    lchb_pkg::lchb_fetch_s fi = '0;
    int fails = 0, n_compared = 0;

    always #10 clk_i = ~clk_i; // 50 MHz

    lchb_loop_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bre),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ara),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
        .s_axi_rresp_o(rre), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .fetch_i(fi), .exe_wr_i(ew), .exe_wr_idx_i(ei), .exe_wr_data_i(ed),
        .fetch_pc_o(pc), .loop_taken_o(tk)
    );

    // ********
    // Tasks
    // ********
    // Compare one value, report at once
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus write of one word, fetch stalled
    task automatic bw(input logic [3:0] ix, input logic [31:0] d, input logic [1:0] er);
        fi <= '0;
        xt = 1'b0;
        awa <= {2'b00, ix, 2'b00};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        cmp({30'h0, bre}, {30'h0, er});
    endtask

    // Bus read of one word with expected data and response
    task automatic rdc(input logic [3:0] ix, input logic [31:0] e, input logic [1:0] er);
        fi <= '0;
        xt = 1'b0;
        ara <= {2'b00, ix, 2'b00};
        arv <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arv && arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        cmp(rd, e);
        cmp({30'h0, rre}, {30'h0, er});
    endtask

    // One fetch cycle: checks the address taken and last loop flag
    task automatic st(input logic a, input logic s, input logic [31:0] t,
                      input logic [31:0] ep, input logic et);
        fi <= '{adv: a, sw_branch: s, sw_target: t};
        @(posedge clk_i);
        // Execute write is a one-cycle pulse; touch it only when raised
        if (ew) ew <= 1'b0;
        cmp(pc, ep);
        cmp({31'h0, tk}, {31'h0, et});
    endtask

    // Walk a loop body np times; fin=0 stops before the last end fetch
    task automatic lp(input logic [31:0] s, input logic [31:0] e, input int np,
                      input logic fin);
        for (int k = 1; k <= np; k++) begin
            while (xp != e) begin
                st(1'b1, 1'b0, 32'h0, xp, xt);
                xt = 1'b0;
                xp++;
            end
            if (k == np && !fin) return;
            st(1'b1, 1'b0, 32'h0, xp, xt);
            xt = (k < np);
            xp = (k < np) ? s : e + 32'h1;
        end
    endtask

    // Counts then verdict, ends the run
    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ********
    // Watchdog
    // ********
    initial begin
        repeat (4000) @(posedge clk_i);
        fails++;
        test_done();
    end

    // ********
    // Tests
    // ********
    initial begin
        xp = `LCHB_RESET_PC;
        xt = 1'b0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped read and unmapped write
        rdc(4'hE, 32'h0, `LCHB_RESP_OKAY);
        rdc(4'hC, 32'h0, `LCHB_RESP_OKAY);
        rdc(4'hF, 32'h0, `LCHB_RESP_SLVERR);
        bw(4'hF, 32'h5, `LCHB_RESP_SLVERR);
        // Byte enables merge into the held word
        bw(4'h9, 32'h1234_5678, `LCHB_RESP_OKAY);
        ws <= 4'h1;
        bw(4'h9, 32'hAABB_CCDD, `LCHB_RESP_OKAY);
        ws <= 4'hF;
        rdc(4'h9, 32'h1234_56DD, `LCHB_RESP_OKAY);
        $display("Test registers done");
        // Counted loop, reload one gives two passes
        bw(4'h0, 32'h5, `LCHB_RESP_OKAY);
        bw(4'h1, 32'h2, `LCHB_RESP_OKAY);
        bw(4'hC, 32'h9, `LCHB_RESP_OKAY);
        bw(4'h3, 32'h1, `LCHB_RESP_OKAY);
        rdc(4'h2, 32'h1, `LCHB_RESP_OKAY);
        rdc(4'h3, 32'h0, `LCHB_RESP_OKAY);
        lp(32'h2, 32'h5, 2, 1'b1);
        rdc(4'h2, 32'h1, `LCHB_RESP_OKAY);
        rdc(4'hE, xp, `LCHB_RESP_OKAY);
        $display("Test short loop done");
        // Single word loop, 511 gives 512 passes
        bw(4'h0, 32'h7, `LCHB_RESP_OKAY);
        bw(4'h1, 32'h7, `LCHB_RESP_OKAY);
        bw(4'h3, 32'h1FF, `LCHB_RESP_OKAY);
        lp(32'h7, 32'h7, 512, 1'b1);
        rdc(4'h2, 32'h1FF, `LCHB_RESP_OKAY);
        $display("Test long loop done");
        // Counter write at the loop end beats the decrement
        bw(4'h0, 32'hA, `LCHB_RESP_OKAY);
        bw(4'h1, 32'hA, `LCHB_RESP_OKAY);
        bw(4'h3, 32'h3, `LCHB_RESP_OKAY);
        lp(32'hA, 32'hA, 3, 1'b0);
        ew <= 1'b1;
        ei <= 4'h2;
        ed <= 32'h7;
        st(1'b1, 1'b0, 32'h0, xp, 1'b1);
        rdc(4'h2, 32'h7, `LCHB_RESP_OKAY);
        // Zero written early cancels the branch
        ew <= 1'b1;
        ed <= 32'h0;
        st(1'b0, 1'b0, 32'h0, 32'hA, 1'b0);
        st(1'b1, 1'b0, 32'h0, 32'hA, 1'b0);
        st(1'b1, 1'b0, 32'h0, 32'hB, 1'b0);
        xp = 32'hC;
        $display("Test conditional exit done");
        // Zero reload clears the counter and enables the end
        bw(4'hC, 32'h1, `LCHB_RESP_OKAY);
        bw(4'h3, 32'h0, `LCHB_RESP_OKAY);
        rdc(4'hC, 32'h9, `LCHB_RESP_OKAY);
        rdc(4'h2, 32'h0, `LCHB_RESP_OKAY);
        bw(4'h0, 32'hD, `LCHB_RESP_OKAY);
        lp(32'h2, 32'hD, 1, 1'b1);
        $display("Test zero reload done");
        // Two ends on one word: higher one wins, then a software branch
        bw(4'hC, 32'h98, `LCHB_RESP_OKAY);
        bw(4'h2, 32'h4, `LCHB_RESP_OKAY);
        bw(4'h4, 32'hF, `LCHB_RESP_OKAY);
        bw(4'h5, 32'h3, `LCHB_RESP_OKAY);
        bw(4'h0, 32'hF, `LCHB_RESP_OKAY);
        lp(32'h3, 32'hF, 3, 1'b0);
        st(1'b1, 1'b1, 32'hF, xp, 1'b0);
        rdc(4'h2, 32'h2, `LCHB_RESP_OKAY);
        // Counter empty: the unconditional end takes over
        bw(4'h2, 32'h0, `LCHB_RESP_OKAY);
        lp(32'hA, 32'hF, 2, 1'b0);
        rdc(4'h2, 32'h0, `LCHB_RESP_OKAY);
        rdc(4'hE, xp, `LCHB_RESP_OKAY);
        $display("Test priority done");
        test_done();
    end
endmodule
